// ### verilog/scm_map.vh
`ifndef SCM_MAP_VH
`define SCM_MAP_VH
// Wishbone register byte offsets.
`define SCM_ADR_CTRL 8'h00
`define SCM_ADR_STATUS 8'h04
`define SCM_ADR_RAW_CAP 8'h08
`define SCM_ADR_RAW_TEMP 8'h0C
`define SCM_ADR_RES_CAP 8'h10
`define SCM_ADR_RES_TEMP 8'h14
`define SCM_ADR_CONV_CYC 8'h18
`define SCM_ADR_COEF0 8'h20
`define SCM_NUM_COEF 11
// Coefficient indices.
`define SCM_C_CAP_GAIN 4'h0
`define SCM_C_CAP_OFS 4'h1
`define SCM_C_TCG 4'h2
`define SCM_C_TCO 4'h3
`define SCM_C_TCG_Q 4'h4
`define SCM_C_TCO_Q 4'h5
`define SCM_C_CAP_Q 4'h6
`define SCM_C_CAP_SH 4'h7
`define SCM_C_T_GAIN 4'h8
`define SCM_C_T_OFS 4'h9
`define SCM_C_T_Q 4'hA
// Control register fields.
`define SCM_CTRL_START_CAP 0
`define SCM_CTRL_START_TEMP 1
`define SCM_CTRL_RAW_MODE 2
`define SCM_CTRL_NONMEAS 3
`define SCM_CTRL_RES_HI 7
`define SCM_CTRL_RES_LO 6
`define SCM_CTRL_NOISE 8
`define SCM_CTRL_INV 11
`define SCM_CTRL_CURVE 15
`define SCM_CTRL_RESET 16'h0080
// Numeric constants.
`define SCM_W 26
`define SCM_FRAC 23
`define SCM_ONE 26'sh080_0000
`define SCM_MAXP 26'sh1FF_FFFF
`define SCM_MINN 26'sh200_0000
`define SCM_OUT_MAX 26'sh0FF_FFFF
`define SCM_RAW_MAX 26'sh07F_FFFF
`define SCM_INV_NUM 48'h4000_0000_0000
`define SCM_INV_BASE 26'sh100_0000
// Conversion times in microseconds and clock rate.
`define SCM_CLK_MHZ 100
`define SCM_T_S0_12 770
`define SCM_T_S0_14 1310
`define SCM_T_S0_16 2390
`define SCM_T_S0_18 4550
`define SCM_T_S1_12 1550
`define SCM_T_S1_14 2850
`define SCM_T_S1_16 5440
`define SCM_T_S1_18 10620
`define SCM_T_T_12 630
`define SCM_T_T_14 1040
`define SCM_T_T_16 1810
`define SCM_T_T_18 3470
`endif

// ### verilog/scm_mul.v
`default_nettype none
`include "scm_map.vh"
module scm_mul (
  // Operands.
  input wire signed [25:0] a_in,
  input wire signed [25:0] b_in,
  // Scaled and clamped product.
  output wire signed [25:0] p_out,
  output wire sat_out
);
  wire signed [51:0] prod;
  wire signed [51:0] shr;
  assign prod = a_in * b_in;
  assign shr = prod >>> `SCM_FRAC;
  assign sat_out = (shr > $signed({{26{1'b0}}, `SCM_MAXP})) || (shr < $signed({{26{1'b1}}, `SCM_MINN}));
  assign p_out = (shr > $signed({{26{1'b0}}, `SCM_MAXP})) ? `SCM_MAXP :
                 (shr < $signed({{26{1'b1}}, `SCM_MINN})) ? `SCM_MINN : shr[25:0];
endmodule // scm_mul
`default_nettype wire

// ### verilog/scm_core.v
// Behaviour
// - two-bit selector picks 12..18 bit resolution
// - default resolution is 16 bits
// - noise mode sets sensor conversion time
// - temperature conversion time follows resolution
// - arithmetic is 26-bit two's complement
// - coefficients are 24-bit sign-magnitude
// - products divided by 2^23
// - saturate and flag overflow
// - 1/C only in normal measurements
// - inversion 2^24 minus 2^46/raw, bounded
// - curve bit selects parabolic or S-shape
// - coefficients shifted left two bits
// - temperature gain factor and corrected input
// - parabolic sensor equations, non-negative bounds
// - S-shaped sensor equations
// - S-shape partial clamps, output 0..2^24-1
// - sensor result unsigned 24 bits
// - raw readings span signed 24-bit range
// - coefficients span signed 24-bit range
// - temperature always parabolic
// - temperature result unsigned 24 bits
// - saturation flag per measurement, cleared otherwise
`default_nettype none
`include "scm_map.vh"
module scm_core (
  // Clock and reset.
  input wire CLOCK_IN,
  input wire RESETN_IN,
  // Wishbone slave.
  input wire WB_CYC_IN,
  input wire WB_STB_IN,
  input wire WB_WE_IN,
  input wire [7:0] WB_ADR_IN,
  input wire [3:0] WB_SEL_IN,
  input wire [31:0] WB_DAT_IN,
  output reg [31:0] WB_DAT_OUT,
  output reg WB_ACK_OUT,
  // Result hand-off.
  output reg DONE_OUT,
  output reg MATH_SAT_OUT,
  output reg [23:0] RESULT_OUT
);
  ////////////////////////////////////////////////////////////////////////////
  localparam S_IDLE = 8'b0000_0001;
  localparam S_INV = 8'b0000_0010;
  localparam S_K1 = 8'b0000_0100;
  localparam S_K2 = 8'b0000_1000;
  localparam S_Z = 8'b0001_0000;
  localparam S_Q = 8'b0010_0000;
  localparam S_OUT = 8'b0100_0000;
  localparam S_DONE = 8'b1000_0000;

  // Conversion time in cycles, looked up from the microsecond tables.
  function [20:0] conv_cyc;
    input is_temp;
    input noise;
    input [1:0] res;
    reg [13:0] us;
    reg [31:0] full;
    begin
      us = 14'h0000;
      case ({is_temp, noise, res})
        4'b0000: us = `SCM_T_S0_12;
        4'b0001: us = `SCM_T_S0_14;
        4'b0010: us = `SCM_T_S0_16;
        4'b0011: us = `SCM_T_S0_18;
        4'b0100: us = `SCM_T_S1_12;
        4'b0101: us = `SCM_T_S1_14;
        4'b0110: us = `SCM_T_S1_16;
        4'b0111: us = `SCM_T_S1_18;
        4'b1000, 4'b1100: us = `SCM_T_T_12;
        4'b1001, 4'b1101: us = `SCM_T_T_14;
        4'b1010, 4'b1110: us = `SCM_T_T_16;
        default: us = `SCM_T_T_18;
      endcase
      full = us * `SCM_CLK_MHZ;
      conv_cyc = full[20:0];
    end
  endfunction

  function signed [25:0] coef;
    input [23:0] c;
    reg signed [25:0] m;
    begin
      m = {1'b0, c[22:0], 2'b00};
      coef = c[23] ? -m : m;
    end
  endfunction

  function signed [25:0] raw_clip;
    input [31:0] d;
    reg signed [25:0] v;
    begin
      v = {{2{d[23]}}, d[23:0]};
      raw_clip = (v < -`SCM_RAW_MAX) ? -`SCM_RAW_MAX : v;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg [15:0] ctrl_ff;
  reg [23:0] coef_ff [0:10];
  reg signed [25:0] raw_cap_ff;
  reg signed [25:0] raw_temp_ff;
  reg [23:0] res_cap_ff;
  reg [23:0] res_temp_ff;
  reg [7:0] state_ff;
  reg is_temp_ff;
  reg raw_mode_ff;
  reg sat_ff;
  reg busy_ff;
  reg [20:0] wait_ff;
  reg signed [25:0] k1_ff;
  reg signed [25:0] k2_ff;
  reg signed [25:0] z_ff;
  reg signed [25:0] acc_ff;
  reg [1:0] sub_ff;
  reg signed [25:0] ma;
  reg signed [25:0] mb;
  wire signed [25:0] mp;
  wire msat;
  reg signed [25:0] inv_val;
  reg inv_sat;
  reg [47:0] quot;
  integer i;

  scm_mul u_mul (
    .a_in(ma),
    .b_in(mb),
    .p_out(mp),
    .sat_out(msat)
  );

  // Saturating add used for every sum in the datapath.
  function [26:0] sadd;
    input signed [25:0] a;
    input signed [25:0] b;
    reg signed [26:0] s;
    begin
      s = {a[25], a} + {b[25], b};
      if (s > $signed({1'b0, `SCM_MAXP})) begin
        sadd = {1'b1, `SCM_MAXP};
      end else if (s < $signed({1'b1, `SCM_MINN})) begin
        sadd = {1'b1, `SCM_MINN};
      end else begin
        sadd = {1'b0, s[25:0]};
      end
    end
  endfunction

  // Value part of the saturating add.
  function signed [25:0] sadd_v;
    input signed [25:0] a;
    input signed [25:0] b;
    reg [26:0] t;
    begin
      t = sadd(a, b);
      sadd_v = t[25:0];
    end
  endfunction

  // Clamp flag of the saturating add.
  function sadd_f;
    input signed [25:0] a;
    input signed [25:0] b;
    reg [26:0] t;
    begin
      t = sadd(a, b);
      sadd_f = t[26];
    end
  endfunction

  // Bound to the non-negative range.
  function signed [25:0] nneg;
    input signed [25:0] v;
    begin
      nneg = (v < 0) ? 26'sh000_0000 : v;
    end
  endfunction

  // Clamp to the unsigned output range; bit 26 flags a clamp.
  function [26:0] oclip;
    input signed [25:0] v;
    begin
      if (v < 0) begin
        oclip = {1'b1, 26'sh000_0000};
      end else if (v > `SCM_OUT_MAX) begin
        oclip = {1'b1, `SCM_OUT_MAX};
      end else begin
        oclip = {1'b0, v};
      end
    end
  endfunction

  wire [26:0] oc = oclip(acc_ff);
  wire curve_shape_sel = ctrl_ff[`SCM_CTRL_CURVE];
  wire [1:0] res_sel = ctrl_ff[`SCM_CTRL_RES_HI:`SCM_CTRL_RES_LO];

  ////////////////////////////////////////////////////////////////////////////
  // 1/C inversion with bound
  always @* begin
    quot = 48'h0000_0000_0000;
    inv_val = raw_cap_ff;
    inv_sat = 1'b0;
    if (raw_cap_ff <= 0) begin
      // Zero or negative raw cannot be inverted meaningfully; saturate high.
      inv_val = `SCM_MAXP;
      inv_sat = 1'b1;
    end else begin
      quot = `SCM_INV_NUM / {22'h00_0000, raw_cap_ff};
      if (quot > 48'h0000_0100_0000 + 48'h0000_0200_0000) begin
        inv_val = `SCM_MINN;
        inv_sat = 1'b1;
      end else begin
        inv_val = `SCM_INV_BASE - $signed(quot[25:0]);
      end
    end
  end

  // Multiplier operand selection per state and sub-step.
  always @* begin
    ma = 26'sh000_0000;
    mb = 26'sh000_0000;
    case (state_ff)
      S_K1: begin
        ma = (sub_ff == 2'b00) ? coef(coef_ff[`SCM_C_TCG_Q]) :
             (sub_ff == 2'b01) ? raw_temp_ff : coef(coef_ff[`SCM_C_TCO_Q]);
        mb = (sub_ff == 2'b00) ? raw_temp_ff : (sub_ff == 2'b01) ? acc_ff : raw_temp_ff;
      end
      S_K2: begin
        ma = raw_temp_ff;
        mb = acc_ff;
      end
      S_Z: begin
        ma = is_temp_ff ? coef(coef_ff[`SCM_C_T_GAIN]) :
             (sub_ff == 2'b00 ? k1_ff : coef(coef_ff[`SCM_C_CAP_GAIN]));
        mb = is_temp_ff ? acc_ff : (sub_ff == 2'b00 ? k2_ff : acc_ff);
      end
      S_Q: begin
        ma = is_temp_ff ? coef(coef_ff[`SCM_C_T_Q]) : coef(coef_ff[`SCM_C_CAP_Q]);
        mb = (!is_temp_ff && curve_shape_sel && z_ff < 0) ? -z_ff : z_ff;
      end
      S_OUT: begin
        ma = z_ff;
        mb = acc_ff;
      end
      default: begin
        ma = 26'sh000_0000;
        mb = 26'sh000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      ctrl_ff <= `SCM_CTRL_RESET;
      for (i = 0; i < `SCM_NUM_COEF; i = i + 1) begin
        coef_ff[i] <= 24'h00_0000;
      end
      raw_cap_ff <= 26'sh000_0000;
      raw_temp_ff <= 26'sh000_0000;
      res_cap_ff <= 24'h00_0000;
      res_temp_ff <= 24'h00_0000;
      state_ff <= S_IDLE;
      is_temp_ff <= 1'b0;
      raw_mode_ff <= 1'b0;
      sat_ff <= 1'b0;
      busy_ff <= 1'b0;
      wait_ff <= 21'h00_0000;
      k1_ff <= 26'sh000_0000;
      k2_ff <= 26'sh000_0000;
      z_ff <= 26'sh000_0000;
      acc_ff <= 26'sh000_0000;
      sub_ff <= 2'b00;
      WB_DAT_OUT <= 32'h0000_0000;
      WB_ACK_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      MATH_SAT_OUT <= 1'b0;
      RESULT_OUT <= 24'h00_0000;
    end else begin
      DONE_OUT <= 1'b0;
      WB_ACK_OUT <= WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
      if (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) begin
        WB_DAT_OUT <= 32'h0000_0000;
        if (WB_WE_IN && WB_SEL_IN == 4'hF) begin
          if (WB_ADR_IN == `SCM_ADR_CTRL && !busy_ff) begin
            ctrl_ff <= WB_DAT_IN[15:0];
            if (WB_DAT_IN[`SCM_CTRL_START_CAP] || WB_DAT_IN[`SCM_CTRL_START_TEMP]) begin
              busy_ff <= 1'b1;
              sat_ff <= 1'b0;
              is_temp_ff <= WB_DAT_IN[`SCM_CTRL_START_TEMP];
              raw_mode_ff <= WB_DAT_IN[`SCM_CTRL_RAW_MODE];
              wait_ff <= conv_cyc(WB_DAT_IN[`SCM_CTRL_START_TEMP], WB_DAT_IN[`SCM_CTRL_NOISE],
                                  WB_DAT_IN[`SCM_CTRL_RES_HI:`SCM_CTRL_RES_LO]);
            end else if (WB_DAT_IN[`SCM_CTRL_NONMEAS]) begin
              MATH_SAT_OUT <= 1'b0;
            end
          end else if (WB_ADR_IN == `SCM_ADR_RAW_CAP) begin
            raw_cap_ff <= raw_clip(WB_DAT_IN);
          end else if (WB_ADR_IN == `SCM_ADR_RAW_TEMP) begin
            raw_temp_ff <= raw_clip(WB_DAT_IN);
          end else if (WB_ADR_IN >= `SCM_ADR_COEF0 && WB_ADR_IN[1:0] == 2'b00 &&
                       WB_ADR_IN[7:2] < (`SCM_ADR_COEF0 >> 2) + `SCM_NUM_COEF) begin
            coef_ff[WB_ADR_IN[5:2] - 4'h8] <= WB_DAT_IN[23:0];
          end
        end else if (!WB_WE_IN) begin
          case (WB_ADR_IN)
            `SCM_ADR_CTRL: WB_DAT_OUT <= {16'h0000, ctrl_ff};
            `SCM_ADR_STATUS: WB_DAT_OUT <= {30'h0000_0000, busy_ff, MATH_SAT_OUT};
            `SCM_ADR_RAW_CAP: WB_DAT_OUT <= {{6{raw_cap_ff[25]}}, raw_cap_ff};
            `SCM_ADR_RAW_TEMP: WB_DAT_OUT <= {{6{raw_temp_ff[25]}}, raw_temp_ff};
            `SCM_ADR_RES_CAP: WB_DAT_OUT <= {8'h00, res_cap_ff};
            `SCM_ADR_RES_TEMP: WB_DAT_OUT <= {8'h00, res_temp_ff};
            `SCM_ADR_CONV_CYC: WB_DAT_OUT <= {11'h000, conv_cyc(1'b0, ctrl_ff[`SCM_CTRL_NOISE], res_sel)};
            default: WB_DAT_OUT <= 32'h0000_0000;
          endcase
        end
      end
      sub_ff <= 2'b00;
      case (state_ff)
        S_IDLE: begin
          if (busy_ff) begin
            if (wait_ff != 21'h00_0000) begin
              wait_ff <= wait_ff - 21'h00_0001;
            end else if (is_temp_ff) begin
              // The two-bit alignment already supplies the factor of four.
              acc_ff <= sadd_v(raw_temp_ff, coef(coef_ff[`SCM_C_T_OFS]));
              sat_ff <= sadd_f(raw_temp_ff, coef(coef_ff[`SCM_C_T_OFS]));
              state_ff <= S_Z;
            end else if (raw_mode_ff) begin
              acc_ff <= raw_cap_ff;
              state_ff <= S_DONE;
            end else begin
              state_ff <= S_INV;
            end
          end
        end
        S_INV: begin
          if (ctrl_ff[`SCM_CTRL_INV]) begin
            raw_cap_ff <= inv_val;
            sat_ff <= sat_ff | inv_sat;
          end
          state_ff <= S_K1;
        end
        S_K1: begin
          // Sub-steps: quad*T, T*(..+4tcg) -> K1, quad_o*T.
          sub_ff <= sub_ff + 2'b01;
          sat_ff <= sat_ff | msat;
          if (sub_ff == 2'b00) begin
            acc_ff <= sadd_v(mp, coef(coef_ff[`SCM_C_TCG]));
          end else if (sub_ff == 2'b01) begin
            k1_ff <= sadd_v(`SCM_ONE, mp);
          end else begin
            acc_ff <= sadd_v(mp, coef(coef_ff[`SCM_C_TCO]));
            state_ff <= S_K2;
          end
        end
        S_K2: begin
          sat_ff <= sat_ff | msat;
          k2_ff <= sadd_v(sadd_v(coef(coef_ff[`SCM_C_CAP_OFS]), raw_cap_ff), mp);
          state_ff <= S_Z;
        end
        S_Z: begin
          sat_ff <= sat_ff | msat;
          if (!is_temp_ff && sub_ff == 2'b00) begin
            acc_ff <= mp;
            sub_ff <= 2'b01;
          end else begin
            z_ff <= (is_temp_ff || !curve_shape_sel) ? nneg(sadd_v(mp, `SCM_ONE)) : mp;
            state_ff <= S_Q;
          end
        end
        S_Q: begin
          sat_ff <= sat_ff | msat;
          acc_ff <= sadd_v(mp, `SCM_ONE);
          state_ff <= S_OUT;
        end
        S_OUT: begin
          sat_ff <= sat_ff | msat;
          acc_ff <= is_temp_ff ? sadd_v(mp, coef(coef_ff[`SCM_C_T_OFS + 4'h1])) :
                    curve_shape_sel ? sadd_v(sadd_v(mp, `SCM_ONE), coef(coef_ff[`SCM_C_CAP_SH])) :
                    sadd_v(mp, coef(coef_ff[`SCM_C_CAP_SH]));
          state_ff <= S_DONE;
        end
        S_DONE: begin
          if (is_temp_ff) begin
            res_temp_ff <= oc[23:0];
          end else begin
            res_cap_ff <= oc[23:0];
          end
          RESULT_OUT <= oc[23:0];
          MATH_SAT_OUT <= raw_mode_ff ? sat_ff : (sat_ff | oc[26]);
          DONE_OUT <= 1'b1;
          busy_ff <= 1'b0;
          state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule // scm_core
`default_nettype wire

// ### test/scm_sink.sv
`default_nettype none
module scm_sink (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rstn_in,
  // Result hand-off from the datapath.
  input wire logic done_in,
  input wire logic sat_in,
  input wire logic [23:0] result_in,
  // What the output stage has latched.
  output logic [7:0] done_cnt_out,
  output logic [23:0] last_out,
  output logic last_sat_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // The output stage takes a result only on the done pulse, so a stretched pulse shows as a double count.
  // result capture
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      done_cnt_out <= 8'h00;
      last_out <= 24'h00_0000;
      last_sat_out <= 1'b0;
    end else if (done_in) begin
      done_cnt_out <= done_cnt_out + 8'h01;
      last_out <= result_in;
      last_sat_out <= sat_in;
    end
  end
endmodule // scm_sink
`default_nettype wire

// ### test/scm_core_chk.sv
`default_nettype none
module scm_core_chk (
  // Clock and reset.
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  // Bus.
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  // Results.
  input wire logic DONE_OUT,
  input wire logic MATH_SAT_OUT,
  input wire logic [23:0] RESULT_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);
  property p_ack_take;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT;
  endproperty
  a_ack_take: assert property (p_ack_take) else $error("no ack after request");
  property p_ack_idle;
    !(WB_CYC_IN && WB_STB_IN) |=> !WB_ACK_OUT;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
  property p_ack_one;
    WB_ACK_OUT |=> !WB_ACK_OUT;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_done_one;
    DONE_OUT |=> !DONE_OUT;
  endproperty
  a_done_one: assert property (p_done_one) else $error("done longer than one cycle");
  property p_result_hold;
    !DONE_OUT |-> $stable(RESULT_OUT);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved without done");
  property p_sat_rise;
    $rose(MATH_SAT_OUT) |-> DONE_OUT;
  endproperty
  a_sat_rise: assert property (p_sat_rise) else $error("saturation set outside a result");
  property p_sat_fall;
    $fell(MATH_SAT_OUT) |-> WB_ACK_OUT || $past(WB_ACK_OUT) || DONE_OUT;
  endproperty
  a_sat_fall: assert property (p_sat_fall) else $error("saturation cleared without command");
  property p_status_sat;
    WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == 8'h04 |-> WB_DAT_OUT[0] == MATH_SAT_OUT;
  endproperty
  a_status_sat: assert property (p_status_sat) else $error("status disagrees with flag");
  property p_unmapped;
    WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == 8'h1C |-> WB_DAT_OUT == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // scm_core_chk
bind scm_core scm_core_chk scm_core_chk_inst (.CLOCK_IN(CLOCK_IN), .RESETN_IN(RESETN_IN), .WB_CYC_IN(WB_CYC_IN),
  .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_DAT_OUT(WB_DAT_OUT),
  .WB_ACK_OUT(WB_ACK_OUT), .DONE_OUT(DONE_OUT), .MATH_SAT_OUT(MATH_SAT_OUT), .RESULT_OUT(RESULT_OUT));
`default_nettype wire

// ### test/scm_core_tb.sv
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module scm_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  wire [31:0] rdat;
  wire ack;
  wire done;
  wire sat;
  wire [23:0] result;
  wire [7:0] done_cnt;
  wire [23:0] last_res;
  wire last_sat;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int conv_us [8] = '{770, 1310, 2390, 4550, 1550, 2850, 5440, 10620};
  logic [31:0] rd;
  int n;
  ////////////////////////////////////////////////////////////////////////////////
  scm_core scm_core_inst (.CLOCK_IN(clock), .RESETN_IN(resetn), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .DONE_OUT(done),
    .MATH_SAT_OUT(sat), .RESULT_OUT(result));
  scm_sink scm_sink_inst (.clk_in(clock), .rstn_in(resetn), .done_in(done), .sat_in(sat), .result_in(result),
    .done_cnt_out(done_cnt), .last_out(last_res), .last_sat_out(last_sat));
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // The request is held until ack is seen at an edge, then dropped for one idle cycle.
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    @(posedge clock);
    while (ack !== 1'b1 && k < 50) begin
      @(posedge clock);
      k++;
    end
    if (k >= 50) begin
      err_count++;
      $display("unexpected at %0t: no bus acknowledge", $time);
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
    wb_cycle(1'b1, a, d, 4'hF);
  endtask
  task automatic wb_read(input logic [7:0] a);
    wb_cycle(1'b0, a, 32'h0000_0000, 4'hF);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // One full sensor measurement of 77000 cycles dominates the run, so the ceiling sits about 18000 cycles above it.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 95000) begin
      err_count++;
      $display("unexpected at %0t: run timed out", $time);
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    wb_read(8'h00);
    `CHK(rd, 32'h0000_0080)
    wb_read(8'h18);
    `CHK(rd, 32'(2390 * 100))
    for (int i = 0; i < 8; i++) begin
      wb_write(8'h00, {23'h0, i[2], i[1:0], 6'h00});
      wb_read(8'h18);
      `CHK(rd, 32'(conv_us[i] * 100))
    end
    wb_read(8'h1C);
    `CHK(rd, 32'h0000_0000)
    wb_cycle(1'b1, 8'h00, 32'h0000_0000, 4'h1);
    wb_read(8'h00);
    `CHK(rd, 32'h0000_01C0)
    // Unity gain, no temperature terms, no inversion and zero shift, so the result is raw plus one half scale.
    // inversion off here
    wb_write(8'h00, 32'h0000_0000);
    wb_write(8'h20, 32'h0020_0000);
    wb_write(8'h08, 32'h0010_0000);
    wb_write(8'h0C, 32'h0000_0000);
    wb_write(8'h00, 32'h0000_0001);
    wb_read(8'h04);
    `CHK(rd[1], 1'b1)
    wb_write(8'h00, 32'h0000_0080);
    n = 0;
    while (done_cnt !== 8'h01 && n < 90000) begin
      @(posedge clock);
      n++;
    end
    `CHK(last_res, 24'h90_0000)
    `CHK(last_sat, 1'b0)
    wb_read(8'h10);
    `CHK(rd[23:0], 24'h90_0000)
    wb_read(8'h18);
    `CHK(rd, 32'(770 * 100))
    wb_write(8'h00, 32'h0000_0008);
    wb_read(8'h04);
    `CHK(rd[1:0], 2'b00)
    repeat (20) @(posedge clock);
    `CHK(done_cnt, 8'h01)
    end_sim();
  end
endmodule // scm_core_tb
`default_nettype wire
